// *** verilog/dpal_pkg.sv ***
/*
  Constants, register map and state encoding for the dual process alarm logic.
  Assumes a 10 MHz core clock and a word-aligned AHB-Lite register window.
*/
package dpal_pkg;

  // time base: one second expressed in core clock cycles
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SECOND_NS     = 1000000000;
  localparam int unsigned TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_W         = 24;

  // field widths
  localparam int unsigned SP_W   = 18;     // signed display units
  localparam int unsigned DB_W   = 17;     // unsigned display units
  localparam int unsigned TIME_W = 12;     // whole seconds
  localparam int unsigned CMP_W  = 20;     // headroom for setpoint +/- deadband

  // longest wait and silence time in seconds
  localparam logic [11:0] MAX_SECONDS = 12'hE10;

  // register byte offsets; channel two sits one stride above channel one
  localparam logic [7:0] CH_STRIDE    = 8'h20;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SETPOINT = 8'h04;
  localparam logic [7:0] OFS_DEADBAND = 8'h08;
  localparam logic [7:0] OFS_WAIT     = 8'h0C;
  localparam logic [7:0] OFS_SILENCE  = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h40;

  // control register bit positions
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_HIGH_BIT = 1;
  localparam int unsigned CTRL_NC_BIT   = 2;
  localparam int unsigned CTRL_ALT_BIT  = 3;

  // status register layout: one byte per channel, then shared bits
  localparam int unsigned ST_CH_STRIDE = 8;
  localparam int unsigned ST_COND_BIT  = 2;
  localparam int unsigned ST_SW_BIT    = 3;
  localparam int unsigned ST_ANN_BIT   = 4;
  localparam int unsigned ST_PWR_BIT   = 16;
  localparam int unsigned ST_REF_BIT   = 17;
  localparam int unsigned ST_SEL_BIT   = 18;

  // reset values: disabled, high acting, open when normal, no alternation
  localparam logic [3:0]        CTRL_RST     = 4'h2;
  localparam logic [SP_W-1:0]   SETPOINT_RST = 18'h00000;
  localparam logic [DB_W-1:0]   DEADBAND_RST = 17'h00000;
  localparam logic [TIME_W-1:0] TIME_RST     = 12'h000;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_WAIT    = 2'b01,
    ST_ACTIVE  = 2'b10,
    ST_SILENCE = 2'b11
  } dpal_state_e;

endpackage

// *** verilog/dpal_pin_timebase.sv ***
/*
  Pin synchronisers and one-second tick divider for the dual process alarm logic.
  Assumes the accept button and loop power sense arrive asynchronously on pins.
*/
`timescale 1ns/1ps

module dpal_pin_timebase #(
  parameter int unsigned TICK_CYCLES = dpal_pkg::TICK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic accept_button_pin,
  input  wire logic loop_power_pin,
  output logic      accept_pulse,
  output logic      loop_power_ok,
  output logic      sec_tick
);

  typedef struct packed {
    logic                        btn_s1;
    logic                        btn_s2;
    logic                        btn_prev;
    logic                        pwr_s1;
    logic                        pwr_s2;
    logic [dpal_pkg::DIV_W-1:0]  div;
    logic                        tick;
    logic                        accept;
  } dpal_tb_s;

  dpal_tb_s r;
  dpal_tb_s next_r;

  // two-stage sync; only the second stage feeds the edge detector
  always_comb begin
    next_r          = r;
    next_r.btn_s1   = accept_button_pin;
    next_r.btn_s2   = r.btn_s1;
    next_r.btn_prev = r.btn_s2;
    next_r.pwr_s1   = loop_power_pin;
    next_r.pwr_s2   = r.pwr_s1;
    next_r.accept   = r.btn_s2 & ~r.btn_prev;   // press edge, one pulse
    next_r.tick     = 1'b0;
    if (r.div == dpal_pkg::DIV_W'(TICK_CYCLES - 1)) begin
      next_r.div  = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.div = r.div + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign accept_pulse  = r.accept;
  assign loop_power_ok = r.pwr_s2;
  assign sec_tick      = r.tick;

endmodule

// *** verilog/dpal_top.sv ***
/*
  Dual process alarm logic: two alarm channels compared against the displayed
  process value, with deadband, activation wait, accept/silence and display
  alternation, configured over an AHB-Lite slave.
  Assumes the displayed value comes from logic on core_clk; the accept button
  and loop power sense are asynchronous pins.
*/
// Functional notes
// - two alarm channels, each with its own independent parameter set.
// - per-channel enable; toggling it never touches other stored parameters.
// - alarm condition when displayed value reaches setpoint in set direction.
// - setpoints accepted anywhere across the full permitted loop span.
// - each channel independently selectable as high or low acting.
// - polarity selects switch open or closed when not in alarm.
// - loss of loop power forces both switch outputs open.
// - high alarm clears only below setpoint minus deadband.
// - activation wait programmable in one-second steps up to 3600 s.
// - wait of zero activates the output at once.
// - output activates only after condition persists for whole wait; here the first second runs on the free-running tick and may be short.
// - annunciator flashes during the wait, steady once output activates.
// - silence time programmable in one-second steps up to 3600 s.
// - nonzero silence time turns the push button into an accept input.
// - accept returns the output to non-alarm for the silence period.
// - condition still present at silence end reactivates the output.
// - annunciator flashes during silence until expiry or condition clears.
// - alternate option flips display between value and reference text.
// - no display alternation during the activation wait.
// - display alternation suppressed for the whole silence period.
// - comparison uses the displayed value, tare offset included.
// - both outputs active shows both reference texts in turn.
`timescale 1ns/1ps

module dpal_top #(
  parameter int unsigned TICK_CYCLES = dpal_pkg::TICK_CYCLES
) (
  input  wire logic                             core_clk,
  input  wire logic                             srst,
  // ahb-lite slave
  input  wire logic                             hsel,
  input  wire logic [31:0]                      haddr,
  input  wire logic [1:0]                       htrans,
  input  wire logic                             hwrite,
  input  wire logic [2:0]                       hsize,
  input  wire logic [31:0]                      hwdata,
  input  wire logic                             hready,
  output logic                                  hreadyout,
  output logic                                  hresp,
  output logic      [31:0]                      hrdata,
  // process side
  input  wire logic signed [dpal_pkg::SP_W-1:0] display_value,
  input  wire logic                             accept_button_pin,
  input  wire logic                             loop_power_pin,
  // alarm side
  output logic      [1:0]                       alarm_switch_closed,
  output logic      [1:0]                       annunciator_on,
  output logic                                  display_show_reference,
  output logic                                  display_reference_sel
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    // configuration, one entry per channel
    logic [1:0]                                cfg_en;
    logic [1:0]                                cfg_high;
    logic [1:0]                                cfg_nc;
    logic [1:0]                                cfg_alt;
    logic [1:0][dpal_pkg::SP_W-1:0]            setpoint;
    logic [1:0][dpal_pkg::DB_W-1:0]            deadband;
    logic [1:0][dpal_pkg::TIME_W-1:0]          wait_sec;
    logic [1:0][dpal_pkg::TIME_W-1:0]          silence_sec;
    // channel sequencing
    logic [1:0]                                cond;
    dpal_pkg::dpal_state_e [1:0]               st;
    logic [1:0][dpal_pkg::TIME_W-1:0]          cnt;
    logic                                      blink;
    // display alternation
    logic                                      disp_ref;
    logic                                      disp_sel;
    // bus data phase
    logic                                      dph_act;
    logic                                      dph_wr;
    logic [7:0]                                dph_addr;
    logic [31:0]                               rdata;
    // registered pin outputs
    logic [1:0]                                sw_closed;
    logic [1:0]                                annun;
  } dpal_top_s;

  dpal_top_s r;
  dpal_top_s next_r;

  logic accept_pulse;
  logic loop_power_ok;
  logic sec_tick;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // register address match for a channel-relative offset
  function automatic logic dpal_hit(input logic [7:0] a, input logic ch, input logic [7:0] ofs);
    return a == ((ch ? dpal_pkg::CH_STRIDE : 8'h00) + ofs);
  endfunction

  // second counts are held to the documented maximum
  function automatic logic [dpal_pkg::TIME_W-1:0] dpal_clamp(input logic [31:0] w);
    if (w > 32'(dpal_pkg::MAX_SECONDS)) begin
      return dpal_pkg::MAX_SECONDS;
    end
    return w[dpal_pkg::TIME_W-1:0];
  endfunction

  // sign-extend a setpoint into the comparison width
  function automatic logic signed [dpal_pkg::CMP_W-1:0] dpal_sx(
    input logic [dpal_pkg::SP_W-1:0] v);
    return {{(dpal_pkg::CMP_W - dpal_pkg::SP_W){v[dpal_pkg::SP_W-1]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and one-second time base

  dpal_pin_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .core_clk          (core_clk),
    .srst              (srst),
    .accept_button_pin (accept_button_pin),
    .loop_power_pin    (loop_power_pin),
    .accept_pulse      (accept_pulse),
    .loop_power_ok     (loop_power_ok),
    .sec_tick          (sec_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic                               ch;
    logic signed [dpal_pkg::CMP_W-1:0]  pv;
    logic signed [dpal_pkg::CMP_W-1:0]  sp;
    logic signed [dpal_pkg::CMP_W-1:0]  db;
    logic [1:0]                         elig;
    logic [dpal_pkg::TIME_W-1:0]        cnt_inc;
    logic [31:0]                        rd;
    ch      = 1'b0;
    pv      = dpal_sx(display_value);
    sp      = '0;
    db      = '0;
    elig    = 2'b00;
    cnt_inc = '0;
    rd      = 32'h00000000;
    next_r  = r;

    // data phase write; upper address bits were checked at capture
    if (r.dph_act && r.dph_wr) begin
      for (int c = 0; c < 2; c++) begin
        ch = c[0];
        if (dpal_hit(r.dph_addr, ch, dpal_pkg::OFS_CTRL)) begin
          next_r.cfg_en[c]   = hwdata[dpal_pkg::CTRL_EN_BIT];
          next_r.cfg_high[c] = hwdata[dpal_pkg::CTRL_HIGH_BIT];
          next_r.cfg_nc[c]   = hwdata[dpal_pkg::CTRL_NC_BIT];
          next_r.cfg_alt[c]  = hwdata[dpal_pkg::CTRL_ALT_BIT];
        end
        if (dpal_hit(r.dph_addr, ch, dpal_pkg::OFS_SETPOINT)) begin
          next_r.setpoint[c] = hwdata[dpal_pkg::SP_W-1:0];
        end
        if (dpal_hit(r.dph_addr, ch, dpal_pkg::OFS_DEADBAND)) begin
          next_r.deadband[c] = hwdata[dpal_pkg::DB_W-1:0];
        end
        if (dpal_hit(r.dph_addr, ch, dpal_pkg::OFS_WAIT)) begin
          next_r.wait_sec[c] = dpal_clamp(hwdata);
        end
        if (dpal_hit(r.dph_addr, ch, dpal_pkg::OFS_SILENCE)) begin
          next_r.silence_sec[c] = dpal_clamp(hwdata);
        end
      end
    end

    if (sec_tick) begin
      next_r.blink = ~r.blink;
    end

    // each channel runs on its own parameters
    for (int c = 0; c < 2; c++) begin
      sp      = dpal_sx(r.setpoint[c]);
      db      = {{(dpal_pkg::CMP_W - dpal_pkg::DB_W){1'b0}}, r.deadband[c]};
      cnt_inc = r.cnt[c] + 1'b1;
      // raw displayed value, tare already applied upstream
      if (!r.cfg_en[c]) begin
        next_r.cond[c] = 1'b0;
      end else if (r.cfg_high[c]) begin
        if (pv >= sp) begin
          next_r.cond[c] = 1'b1;
        end else if (pv < sp - db) begin
          next_r.cond[c] = 1'b0;
        end
      end else begin
        if (pv <= sp) begin
          next_r.cond[c] = 1'b1;
        end else if (pv > sp + db) begin
          next_r.cond[c] = 1'b0;
        end
      end

      case (r.st[c])
        dpal_pkg::ST_IDLE: begin
          next_r.cnt[c] = '0;
          if (r.cond[c]) begin
            if (r.wait_sec[c] == '0) begin
              next_r.st[c] = dpal_pkg::ST_ACTIVE;
            end else begin
              next_r.st[c] = dpal_pkg::ST_WAIT;
            end
          end
        end
        dpal_pkg::ST_WAIT: begin
          if (!r.cond[c]) begin
            next_r.st[c] = dpal_pkg::ST_IDLE;
          end else if (sec_tick) begin
            next_r.cnt[c] = cnt_inc;
            if (cnt_inc >= r.wait_sec[c]) begin
              next_r.st[c] = dpal_pkg::ST_ACTIVE;
            end
          end
        end
        dpal_pkg::ST_ACTIVE: begin
          next_r.cnt[c] = '0;
          if (!r.cond[c]) begin
            next_r.st[c] = dpal_pkg::ST_IDLE;
          end else if (accept_pulse && r.silence_sec[c] != '0) begin
            next_r.st[c] = dpal_pkg::ST_SILENCE;
          end
        end
        dpal_pkg::ST_SILENCE: begin
          if (!r.cond[c]) begin
            next_r.st[c] = dpal_pkg::ST_IDLE;
          end else if (sec_tick) begin
            next_r.cnt[c] = cnt_inc;
            if (cnt_inc >= r.silence_sec[c]) begin
              next_r.st[c] = dpal_pkg::ST_ACTIVE;
              next_r.cnt[c] = '0;
            end
          end
        end
        default: begin
          next_r.st[c] = dpal_pkg::ST_IDLE;
        end
      endcase

      if (!r.cfg_en[c]) begin
        next_r.st[c] = dpal_pkg::ST_IDLE;
      end

      next_r.sw_closed[c] = loop_power_ok
                          & ((next_r.st[c] == dpal_pkg::ST_ACTIVE) ^ r.cfg_nc[c]);

      // flash while waiting, steady when active
      case (next_r.st[c])
        dpal_pkg::ST_ACTIVE:  next_r.annun[c] = 1'b1;
        dpal_pkg::ST_WAIT:    next_r.annun[c] = next_r.blink;
        dpal_pkg::ST_SILENCE: next_r.annun[c] = next_r.blink;
        default:              next_r.annun[c] = 1'b0;
      endcase

      // only an active output may alternate
      elig[c] = r.cfg_alt[c] & (next_r.st[c] == dpal_pkg::ST_ACTIVE);
    end

    // alternate value and reference text each second
    if (sec_tick) begin
      if (r.disp_ref) begin
        next_r.disp_ref = 1'b0;
      end else if (elig != 2'b00) begin
        next_r.disp_ref = 1'b1;
        next_r.disp_sel = elig[~r.disp_sel] ? ~r.disp_sel : r.disp_sel;
      end
    end
    // drop a reference at once when its channel stops being eligible
    if (!elig[next_r.disp_sel]) begin
      next_r.disp_ref = 1'b0;
    end

    // address phase capture; anything above 0xFF is unmapped
    next_r.dph_act = hsel & htrans[1] & hready;
    if (next_r.dph_act) begin
      next_r.dph_wr   = hwrite;
      next_r.dph_addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
    end

    // read data from post-write values so a read right after a write sees it
    if (next_r.dph_act && !hwrite && haddr[31:8] == 24'h000000) begin
      for (int c = 0; c < 2; c++) begin
        ch = c[0];
        if (dpal_hit(haddr[7:0], ch, dpal_pkg::OFS_CTRL)) begin
          rd[dpal_pkg::CTRL_EN_BIT]   = next_r.cfg_en[c];
          rd[dpal_pkg::CTRL_HIGH_BIT] = next_r.cfg_high[c];
          rd[dpal_pkg::CTRL_NC_BIT]   = next_r.cfg_nc[c];
          rd[dpal_pkg::CTRL_ALT_BIT]  = next_r.cfg_alt[c];
        end
        if (dpal_hit(haddr[7:0], ch, dpal_pkg::OFS_SETPOINT)) begin
          rd = 32'(dpal_sx(next_r.setpoint[c]));
        end
        if (dpal_hit(haddr[7:0], ch, dpal_pkg::OFS_DEADBAND)) begin
          rd[dpal_pkg::DB_W-1:0] = next_r.deadband[c];
        end
        if (dpal_hit(haddr[7:0], ch, dpal_pkg::OFS_WAIT)) begin
          rd[dpal_pkg::TIME_W-1:0] = next_r.wait_sec[c];
        end
        if (dpal_hit(haddr[7:0], ch, dpal_pkg::OFS_SILENCE)) begin
          rd[dpal_pkg::TIME_W-1:0] = next_r.silence_sec[c];
        end
      end
      if (haddr[7:0] == dpal_pkg::OFS_STATUS) begin
        for (int c = 0; c < 2; c++) begin
          rd[c*dpal_pkg::ST_CH_STRIDE +: 2]                  = r.st[c];
          rd[c*dpal_pkg::ST_CH_STRIDE + dpal_pkg::ST_COND_BIT] = r.cond[c];
          rd[c*dpal_pkg::ST_CH_STRIDE + dpal_pkg::ST_SW_BIT]   = r.sw_closed[c];
          rd[c*dpal_pkg::ST_CH_STRIDE + dpal_pkg::ST_ANN_BIT]  = r.annun[c];
        end
        rd[dpal_pkg::ST_PWR_BIT] = loop_power_ok;
        rd[dpal_pkg::ST_REF_BIT] = r.disp_ref;
        rd[dpal_pkg::ST_SEL_BIT] = r.disp_sel;
      end
    end
    // hold last read word otherwise; unmapped reads return zero
    if (next_r.dph_act && !hwrite) begin
      next_r.rdata = rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk) begin
    if (srst) begin
      r             <= '0;
      r.cfg_en      <= {2{dpal_pkg::CTRL_RST[dpal_pkg::CTRL_EN_BIT]}};
      r.cfg_high    <= {2{dpal_pkg::CTRL_RST[dpal_pkg::CTRL_HIGH_BIT]}};
      r.cfg_nc      <= {2{dpal_pkg::CTRL_RST[dpal_pkg::CTRL_NC_BIT]}};
      r.cfg_alt     <= {2{dpal_pkg::CTRL_RST[dpal_pkg::CTRL_ALT_BIT]}};
      r.setpoint    <= {2{dpal_pkg::SETPOINT_RST}};
      r.deadband    <= {2{dpal_pkg::DEADBAND_RST}};
      r.wait_sec    <= {2{dpal_pkg::TIME_RST}};
      r.silence_sec <= {2{dpal_pkg::TIME_RST}};
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = r.rdata;

  assign alarm_switch_closed    = r.sw_closed;
  assign annunciator_on         = r.annun;
  assign display_show_reference = r.disp_ref;
  assign display_reference_sel  = r.disp_sel;

endmodule

// *** dv/dpal_top_chk_sva.sv ***
/*
  Port checker for the dual process alarm logic top.
  Assumes it is bound into dpal_top and sees only that module's ports.
*/
`timescale 1ns/1ps

module dpal_top_chk (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        loop_power_pin,
  input wire logic [1:0]  alarm_switch_closed,
  input wire logic [1:0]  annunciator_on,
  input wire logic        display_show_reference,
  input wire logic        display_reference_sel
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  //////////////////////////////////////////////////////////////////////////////
  // read taken, and loop power gone long enough to clear both syncs
  sequence s_read;
    hsel && htrans[1] && hready && !hwrite;
  endsequence
  sequence s_power_lost;
    !loop_power_pin [*5];
  endsequence

  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_ready;
    hreadyout == 1'b1;
  endproperty
  property p_hold;
    !(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata);
  endproperty
  property p_unmapped;
    s_read ##0 (haddr == 32'h0000003C) |=> hrdata == 32'h00000000;
  endproperty
  property p_power;
    s_power_lost |-> alarm_switch_closed == 2'b00;
  endproperty
  property p_rst_out;
    disable iff (1'b0) srst |=> alarm_switch_closed == 2'b00 && annunciator_on == 2'b00;
  endproperty
  property p_rst_disp;
    disable iff (1'b0) srst |=> !display_show_reference && hrdata == 32'h00000000;
  endproperty
  // alternation only starts on a channel whose annunciator is lit
  property p_ref_ann;
    $rose(display_show_reference) |-> annunciator_on[display_reference_sel];
  endproperty

  //////////////////////////////////////////////////////////////////////////////
  a_okay: assert property (p_okay) else $error("bus response not okay");
  a_ready: assert property (p_ready) else $error("bus stalled");
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_power: assert property (p_power) else $error("switch closed without power");
  a_rst_out: assert property (p_rst_out) else $error("outputs live in reset");
  a_rst_disp: assert property (p_rst_disp) else $error("display live in reset");
  a_ref_ann: assert property (p_ref_ann) else $error("reference shown while idle");
endmodule

// *** dv/dpal_sounder.sv ***
/*
  External sounder model on the two alarm switch outputs.
  Assumes each switch is wired to its own sounder.
*/
`timescale 1ns/1ps

module dpal_sounder (
  input  wire logic       core_clk,
  input  wire logic [1:0] switch_closed,
  output logic      [1:0] sounding
);
  // sounder follows its switch a cycle late, like a slow relay
  always_ff @(posedge core_clk) begin
    sounding <= switch_closed;
  end
endmodule

// *** dv/dpal_top_test.sv ***
/*
  Self-checking bench for the dual process alarm logic over AHB-Lite.
  Assumes a zero-wait slave and a 20-cycle second tick.
*/
`timescale 1ns/1ps

module dpal_top_test;
  logic               core_clk = 1'b0;
  logic               srst = 1'b1;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [2:0]         hsize = 3'h2;
  logic [31:0]        hwdata = 32'h0;
  logic               hready, hreadyout, hresp;
  logic [31:0]        hrdata, rd;
  logic signed [17:0] display_value = 18'sh0;
  logic               accept_button_pin = 1'b0;
  logic               loop_power_pin = 1'b1;
  logic [1:0]         alarm_switch_closed, annunciator_on, sounding;
  logic               display_show_reference, display_reference_sel;
  int                 miscompares = 0;
  int                 checks_done = 0;

  assign hready = hreadyout;
  always #50 core_clk = ~core_clk;

  dpal_top #(.TICK_CYCLES(20)) u_dpal_top (.core_clk, .srst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .display_value,
    .accept_button_pin, .loop_power_pin, .alarm_switch_closed, .annunciator_on,
    .display_show_reference, .display_reference_sel);
  dpal_sounder u_dpal_sounder (.core_clk, .switch_closed(alarm_switch_closed), .sounding);

  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single transfer; address held until ready, data held until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  // bounded wait on a switch, then compare it
  task automatic wait_sw(input int ch, input logic v, input int n);
    for (int i = 0; i < n && alarm_switch_closed[ch] !== v; i++) @(posedge core_clk);
    check(alarm_switch_closed[ch], v);
  endtask
  // held past the pin synchroniser so one accept edge is seen
  task automatic press;
    accept_button_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    accept_button_pin <= 1'b0;
    @(posedge core_clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rdchk(8'h00, 32'h2);
    rdchk(8'h20, 32'h2);
    rdchk(8'h3C, 32'h0);
    wr(8'h0C, 32'hFFF);
    rdchk(8'h0C, 32'hE10);
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'h64);
    wr(8'h08, 32'hA);
    wr(8'h00, 32'h3);
    wr(8'h24, 32'hFFFFFFCE);
    rdchk(8'h24, 32'hFFFFFFCE);
    wr(8'h28, 32'h5);
    wr(8'h20, 32'h5);
    wait_sw(1, 1'b1, 10);
    display_value <= 18'sh64;
    wait_sw(0, 1'b1, 10);
    check(annunciator_on[0], 1'b1);
    @(posedge core_clk);
    check(sounding[0], 1'b1);
    display_value <= 18'sh5A;
    repeat (5) @(posedge core_clk);
    check(alarm_switch_closed[0], 1'b1);
    display_value <= 18'sh59;
    wait_sw(0, 1'b0, 10);
    display_value <= -18'sh32;
    wait_sw(1, 1'b0, 10);
    display_value <= -18'sh2D;
    repeat (5) @(posedge core_clk);
    check(alarm_switch_closed[1], 1'b0);
    display_value <= -18'sh2C;
    wait_sw(1, 1'b1, 10);
    wr(8'h00, 32'h2);
    display_value <= 18'sh64;
    repeat (5) @(posedge core_clk);
    check(alarm_switch_closed[0], 1'b0);
    rdchk(8'h04, 32'h64);
    wr(8'h0C, 32'h2);
    wr(8'h00, 32'hB);
    repeat (10) @(posedge core_clk);
    check(alarm_switch_closed[0], 1'b0);
    bus(1'b0, 8'h40, 32'h0);
    check(rd & 32'h20007, 32'h5);
    wait_sw(0, 1'b1, 60);
    check(annunciator_on[0], 1'b1);
    wr(8'h10, 32'h2);
    press();
    wait_sw(0, 1'b0, 10);
    bus(1'b0, 8'h40, 32'h0);
    check(rd & 32'h3, 32'h3);
    check(display_show_reference, 1'b0);
    wait_sw(0, 1'b1, 60);
    wr(8'h10, 32'h0);
    press();
    repeat (5) @(posedge core_clk);
    check(alarm_switch_closed[0], 1'b1);
    wr(8'h00, 32'hB);
    for (int i = 0; i < 60 && display_show_reference !== 1'b1; i++) @(posedge core_clk);
    check(display_show_reference, 1'b1);
    check(display_reference_sel, 1'b0);
    // second channel low acting at the same value, alternating too
    wr(8'h24, 32'h64);
    wr(8'h20, 32'h9);
    wait_sw(1, 1'b1, 10);
    for (int i = 0; i < 80 && !(display_show_reference === 1'b1
         && display_reference_sel === 1'b1); i++) @(posedge core_clk);
    check({display_show_reference, display_reference_sel}, 32'h3);
    loop_power_pin <= 1'b0;
    wait_sw(0, 1'b0, 10);
    wait_sw(1, 1'b0, 10);
    test_done();
  end

  // watchdog well past the few hundred cycles the sequence needs
  initial begin
    repeat (3000) @(posedge core_clk);
    miscompares++;
    test_done();
  end
endmodule

bind dpal_top dpal_top_chk u_dpal_top_chk (.core_clk, .srst, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .loop_power_pin, .alarm_switch_closed,
  .annunciator_on, .display_show_reference, .display_reference_sel);
